// ===== verilog/owps_pkg.sv
// Constants, register map and carrier types of the protection-register program controller.
// Assumes a single 25 MHz clock and a flash-type memory on an asynchronous parallel bus.
package owps_pkg;

	// Memory command codes
	localparam logic [15:0] OWPS_CMD_PROG_SETUP = 16'h0040;
	localparam logic [15:0] OWPS_CMD_PROT_SETUP = 16'h00C0;
	localparam logic [15:0] OWPS_CMD_READ_ID    = 16'h0090;
	localparam logic [15:0] OWPS_CMD_READ_ARRAY = 16'h00FF;
	localparam logic [15:0] OWPS_CMD_CLR_STATUS = 16'h0050;
	localparam logic [15:0] OWPS_LOCK_USER_DATA = 16'hFFFD;

	// Memory status word fields
	localparam int OWPS_SR_READY    = 7;
	localparam int OWPS_SR_PROG_ERR = 4;
	localparam int OWPS_SR_VPP_ERR  = 3;
	localparam int OWPS_SR_LOCKED   = 1;

	// Protection register word map
	localparam int           OWPS_PROT_SEL_BIT  = 7;
	localparam logic [3:0]   OWPS_PROT_LOCK_IDX = 4'h0;

	// Software register offsets
	localparam logic [7:0] OWPS_REG_CMD      = 8'h00;
	localparam logic [7:0] OWPS_REG_ADDR     = 8'h04;
	localparam logic [7:0] OWPS_REG_WDATA    = 8'h08;
	localparam logic [7:0] OWPS_REG_RDATA    = 8'h0C;
	localparam logic [7:0] OWPS_REG_STATUS   = 8'h10;
	localparam logic [7:0] OWPS_REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] OWPS_REG_IRQ_MASK = 8'h18;

	// Operation codes written to the command register
	localparam logic [2:0] OWPS_OP_PROG       = 3'h1;
	localparam logic [2:0] OWPS_OP_PROT_PROG  = 3'h2;
	localparam logic [2:0] OWPS_OP_LOCK_USER  = 3'h3;
	localparam logic [2:0] OWPS_OP_READ_ARRAY = 3'h4;
	localparam logic [2:0] OWPS_OP_READ_ID    = 3'h5;
	localparam logic [2:0] OWPS_OP_CLR_STATUS = 3'h6;

	// Interrupt status bit positions
	localparam int OWPS_IRQ_DONE     = 0;
	localparam int OWPS_IRQ_PROG_ERR = 1;
	localparam int OWPS_IRQ_VPP_ERR  = 2;
	localparam int OWPS_IRQ_LOCKED   = 3;
	localparam int OWPS_IRQ_TIMEOUT  = 4;
	localparam int OWPS_IRQ_W        = 5;

	// Reset values
	localparam logic [21:0] OWPS_ADDR_RST = 22'h000000;
	localparam logic [15:0] OWPS_DATA_RST = 16'h0000;
	localparam logic [4:0]  OWPS_IRQ_RST  = 5'h00;

	// Bus timing
	localparam int OWPS_T_CLK_NS    = 40;
	localparam int OWPS_T_STROBE_NS = 100;
	localparam int OWPS_STROBE_CYC  = (OWPS_T_STROBE_NS + OWPS_T_CLK_NS - 1) / OWPS_T_CLK_NS;
	localparam logic [3:0] OWPS_STROBE_LAST = 4'(OWPS_STROBE_CYC - 1);

	typedef struct packed {
		logic        wr;
		logic [21:0] addr;
		logic [15:0] data;
	} owps_cyc_req_t;

	// Protection word address with every line above A7 low
	function automatic logic [21:0] owps_prot_addr(input logic [3:0] idx);
		owps_prot_addr = 22'h000000;
		owps_prot_addr[OWPS_PROT_SEL_BIT] = 1'b1;
		owps_prot_addr[3:0] = idx;
	endfunction

endpackage

// ===== verilog/owps_cycle.sv
// One asynchronous bus cycle on the memory pins: a write strobe or an output-enable pulse.
// Assumes the memory answers a read within the strobe time and holds no clock.
`timescale 1ns/1ps
module owps_cycle
	import owps_pkg::*;
(
	input  wire logic    i_ref_clk,
	input  wire logic    i_sys_rst,
	input  wire logic    i_start,
	input  owps_cyc_req_t i_req,
	input  wire logic [15:0] i_dq,
	output logic         o_ce_n,
	output logic         o_we_n,
	output logic         o_oe_n,
	output logic         o_dq_oe_n,
	output logic [21:0]  o_addr,
	output logic [15:0]  o_dq,
	output logic         o_done,
	output logic [15:0]  o_rdata
);

	typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} owps_cyc_st_t;

	owps_cyc_st_t state_ff;
	logic [3:0]   cnt_ff;
	logic         wr_ff;

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_ff <= C_IDLE;
			cnt_ff   <= 4'h0;
			wr_ff    <= 1'b0;
		end else begin
			case (state_ff)
				C_IDLE: begin
					if (i_start) begin
						state_ff <= C_SETUP;
						wr_ff    <= i_req.wr;
					end
				end
				C_SETUP: begin
					state_ff <= C_STROBE;
					cnt_ff   <= OWPS_STROBE_LAST;
				end
				C_STROBE: begin
					if (cnt_ff == 4'h0) begin
						state_ff <= C_HOLD;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				C_HOLD:  state_ff <= C_IDLE;
				default: state_ff <= C_IDLE;
			endcase
		end
	end

	// Address and data are set up a cycle before the strobe and held a cycle after it
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ce_n    <= 1'b1;
			o_we_n    <= 1'b1;
			o_oe_n    <= 1'b1;
			o_dq_oe_n <= 1'b1;
			o_addr    <= OWPS_ADDR_RST;
			o_dq      <= OWPS_DATA_RST;
		end else begin
			case (state_ff)
				C_IDLE: begin
					if (i_start) begin
						o_ce_n    <= 1'b0;
						o_addr    <= i_req.addr;
						o_dq      <= i_req.data;
						o_dq_oe_n <= ~i_req.wr;
					end
				end
				C_SETUP: begin
					o_we_n <= ~wr_ff;
					o_oe_n <= wr_ff;
				end
				C_STROBE: begin
					if (cnt_ff == 4'h0) begin
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
					end
				end
				C_HOLD: begin
					o_ce_n    <= 1'b1;
					o_dq_oe_n <= 1'b1;
				end
				default: o_ce_n <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_done  <= 1'b0;
			o_rdata <= OWPS_DATA_RST;
		end else begin
			o_done <= (state_ff == C_HOLD);
			if (state_ff == C_STROBE && cnt_ff == 4'h0 && !wr_ff) begin
				o_rdata <= i_dq;
			end
		end
	end

endmodule

// ===== verilog/owps_ctrl.sv
// Host controller that programs and reads the memory and its protection register.
// Assumes software on a one-cycle register port and the memory alone on the pins.
`timescale 1ns/1ps
module owps_ctrl
	import owps_pkg::*;
#(
	parameter int POLL_LIMIT = 65535
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	output logic             o_irq,
	output logic             o_mem_rst_n,
	output logic             o_mem_ce_n,
	output logic             o_mem_we_n,
	output logic             o_mem_oe_n,
	output logic [21:0]      o_mem_addr,
	output logic [15:0]      o_mem_dq,
	output logic             o_mem_dq_oe_n,
	input  wire logic [15:0] i_mem_dq
);

	typedef enum logic [2:0] {
		M_IDLE, M_CLR, M_SETUP, M_DATA, M_POLL, M_FIN, M_RDCMD, M_RDDATA
	} owps_st_t;

	owps_st_t         state_ff;
	logic [2:0]       op_ff;
	logic [21:0]      addr_ff;
	logic [15:0]      wdata_ff;
	logic [15:0]      result_ff;
	logic [7:0]       sr_ff;
	logic             err_pend_ff;
	logic             issued_ff;
	logic             start_ff;
	owps_cyc_req_t    req_ff;
	owps_cyc_req_t    nxt_req;
	logic [15:0]      poll_cnt_ff;
	logic [OWPS_IRQ_W-1:0] irq_stat_ff;
	logic [OWPS_IRQ_W-1:0] irq_mask_ff;
	logic [OWPS_IRQ_W-1:0] ev;
	logic             cyc_done;
	logic [15:0]      cyc_rdata;
	logic [21:0]      target;
	logic             is_prot;
	logic             cmd_wr;
	logic             poll_end;
	logic             timeout;

	function automatic owps_st_t first_state(input logic [2:0] op);
		case (op)
			OWPS_OP_PROG, OWPS_OP_PROT_PROG, OWPS_OP_LOCK_USER: first_state = M_SETUP;
			OWPS_OP_READ_ARRAY, OWPS_OP_READ_ID:                first_state = M_RDCMD;
			default:                                            first_state = M_IDLE;
		endcase
	endfunction

	assign is_prot  = (op_ff == OWPS_OP_PROT_PROG) || (op_ff == OWPS_OP_LOCK_USER);
	assign cmd_wr   = i_wr && (i_addr == OWPS_REG_CMD) && (state_ff == M_IDLE);
	assign timeout  = (poll_cnt_ff >= 16'(POLL_LIMIT));
	assign poll_end = cyc_done && (state_ff == M_POLL) &&
		(cyc_rdata[OWPS_SR_READY] || timeout);

	always_comb begin
		target = addr_ff;
		if (op_ff == OWPS_OP_LOCK_USER) begin
			target = owps_prot_addr(OWPS_PROT_LOCK_IDX);
		end else if (op_ff == OWPS_OP_PROT_PROG) begin
			target = owps_prot_addr(addr_ff[3:0]);
		end
	end

	always_comb begin
		nxt_req.wr   = 1'b1;
		nxt_req.addr = target;
		nxt_req.data = OWPS_CMD_READ_ARRAY;
		case (state_ff)
			M_CLR:   nxt_req.data = OWPS_CMD_CLR_STATUS;
			M_SETUP: nxt_req.data = is_prot ? OWPS_CMD_PROT_SETUP
			                                : OWPS_CMD_PROG_SETUP;
			M_DATA:  nxt_req.data = (op_ff == OWPS_OP_LOCK_USER) ? OWPS_LOCK_USER_DATA
			                                                     : wdata_ff;
			M_POLL:  nxt_req.wr = 1'b0;
			M_FIN:   nxt_req.data = OWPS_CMD_READ_ARRAY;
			M_RDCMD: nxt_req.data = (op_ff == OWPS_OP_READ_ID) ? OWPS_CMD_READ_ID
			                                                   : OWPS_CMD_READ_ARRAY;
			M_RDDATA: nxt_req.wr = 1'b0;
			default: nxt_req.wr = 1'b1;
		endcase
	end

	// Operation sequencer: one pin cycle per state, repeated in M_POLL until ready or timeout; each issued once and waited for
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_ff  <= M_IDLE;
			op_ff     <= 3'h0;
			issued_ff <= 1'b0;
			start_ff  <= 1'b0;
			req_ff    <= '0;
		end else begin
			start_ff <= 1'b0;
			if (state_ff == M_IDLE) begin
				if (cmd_wr) begin
					op_ff <= i_wdata[2:0];
					// A left-over error is cleared before anything else runs
					if (err_pend_ff || i_wdata[2:0] == OWPS_OP_CLR_STATUS) begin
						state_ff <= M_CLR;
					end else begin
						state_ff <= first_state(i_wdata[2:0]);
					end
				end
			end else if (!issued_ff) begin
				issued_ff <= 1'b1;
				start_ff  <= 1'b1;
				req_ff    <= nxt_req;
			end else if (cyc_done) begin
				issued_ff <= 1'b0;
				case (state_ff)
					M_CLR:    state_ff <= first_state(op_ff);
					M_SETUP:  state_ff <= M_DATA;
					M_DATA:   state_ff <= M_POLL;
					// Busy status says nothing about errors, so keep pulsing OE
					M_POLL:   state_ff <= poll_end ? M_FIN : M_POLL;
					M_FIN:    state_ff <= M_IDLE;
					M_RDCMD:  state_ff <= M_RDDATA;
					M_RDDATA: state_ff <= M_IDLE;
					default:  state_ff <= M_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			poll_cnt_ff <= 16'h0000;
			sr_ff       <= 8'h00;
			result_ff   <= OWPS_DATA_RST;
		end else begin
			if (state_ff == M_DATA) begin
				poll_cnt_ff <= 16'h0000;
			end else if (cyc_done && state_ff == M_POLL && !timeout) begin
				poll_cnt_ff <= poll_cnt_ff + 16'h0001;
			end
			if (cyc_done && state_ff == M_POLL) begin
				sr_ff <= cyc_rdata[7:0];
			end
			if (cyc_done && state_ff == M_RDDATA) begin
				result_ff <= cyc_rdata;
			end
		end
	end

	// Errors are judged once per operation: status errors from a ready status, a timeout from a busy one
	always_comb begin
		ev = '0;
		ev[OWPS_IRQ_DONE]    = (state_ff != M_IDLE) && cyc_done &&
			(state_ff == M_FIN || state_ff == M_RDDATA ||
			 (state_ff == M_CLR && first_state(op_ff) == M_IDLE));
		if (poll_end && cyc_rdata[OWPS_SR_READY]) begin
			ev[OWPS_IRQ_PROG_ERR] = cyc_rdata[OWPS_SR_PROG_ERR];
			ev[OWPS_IRQ_VPP_ERR]  = cyc_rdata[OWPS_SR_VPP_ERR];
			ev[OWPS_IRQ_LOCKED]   = cyc_rdata[OWPS_SR_LOCKED];
		end
		ev[OWPS_IRQ_TIMEOUT] = poll_end && !cyc_rdata[OWPS_SR_READY];
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			err_pend_ff <= 1'b0;
		end else if (|ev[OWPS_IRQ_TIMEOUT:OWPS_IRQ_PROG_ERR]) begin
			err_pend_ff <= 1'b1;
		end else if (cyc_done && state_ff == M_CLR) begin
			err_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			addr_ff     <= OWPS_ADDR_RST;
			wdata_ff    <= OWPS_DATA_RST;
			irq_mask_ff <= OWPS_IRQ_RST;
			irq_stat_ff <= OWPS_IRQ_RST;
		end else begin
			if (i_wr && i_addr == OWPS_REG_ADDR && state_ff == M_IDLE) begin
				addr_ff <= i_wdata[21:0];
			end
			if (i_wr && i_addr == OWPS_REG_WDATA && state_ff == M_IDLE) begin
				wdata_ff <= i_wdata[15:0];
			end
			if (i_wr && i_addr == OWPS_REG_IRQ_MASK) begin
				irq_mask_ff <= i_wdata[OWPS_IRQ_W-1:0];
			end
			// New events win over a write-one-to-clear in the same cycle
			if (i_wr && i_addr == OWPS_REG_IRQ_STAT) begin
				irq_stat_ff <= (irq_stat_ff & ~i_wdata[OWPS_IRQ_W-1:0]) | ev;
			end else begin
				irq_stat_ff <= irq_stat_ff | ev;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata     <= 32'h00000000;
			o_irq       <= 1'b0;
			o_mem_rst_n <= 1'b0;
		end else begin
			o_irq       <= |(irq_stat_ff & irq_mask_ff);
			o_mem_rst_n <= 1'b1;
			o_rdata     <= 32'h00000000;
			if (i_rd) begin
				case (i_addr)
					OWPS_REG_CMD:      o_rdata <= {29'h0, op_ff};
					OWPS_REG_ADDR:     o_rdata <= {10'h0, addr_ff};
					OWPS_REG_WDATA:    o_rdata <= {16'h0, wdata_ff};
					OWPS_REG_RDATA:    o_rdata <= {16'h0, result_ff};
					OWPS_REG_STATUS:   o_rdata <= {16'h0, sr_ff, 6'h0, err_pend_ff,
						state_ff != M_IDLE};
					OWPS_REG_IRQ_STAT: o_rdata <= {27'h0, irq_stat_ff};
					OWPS_REG_IRQ_MASK: o_rdata <= {27'h0, irq_mask_ff};
					default:           o_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	owps_cycle u_cycle (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (start_ff),
		.i_req     (req_ff),
		.i_dq      (i_mem_dq),
		.o_ce_n    (o_mem_ce_n),
		.o_we_n    (o_mem_we_n),
		.o_oe_n    (o_mem_oe_n),
		.o_dq_oe_n (o_mem_dq_oe_n),
		.o_addr    (o_mem_addr),
		.o_dq      (o_mem_dq),
		.o_done    (cyc_done),
		.o_rdata   (cyc_rdata)
	);

endmodule

// ===== verif/owps_ctrl_sva.sv
// Pin-level checks on the memory bus that owps_ctrl drives.
// Assumes it is bound into owps_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module owps_ctrl_sva (
	input wire logic        i_ref_clk,
	input wire logic        i_sys_rst,
	input wire logic        o_mem_ce_n,
	input wire logic        o_mem_we_n,
	input wire logic        o_mem_oe_n,
	input wire logic [21:0] o_mem_addr,
	input wire logic [15:0] o_mem_dq,
	input wire logic        o_mem_dq_oe_n,
	input wire logic [15:0] i_mem_dq
);
	logic setup_ff;
	logic data_ff;
	logic poll_ff;
	logic err_ff;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	// Tracks the program flow: setup write, data write, polls, closing write
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			setup_ff <= 1'b0;
			data_ff  <= 1'b0;
			poll_ff  <= 1'b0;
		end else if ($rose(o_mem_we_n)) begin
			// A data word that happens to equal a setup code is not a new setup
			setup_ff <= !setup_ff && (o_mem_dq == 16'h0040 || o_mem_dq == 16'h00C0);
			data_ff  <= setup_ff;
			poll_ff  <= 1'b0;
		end else if ($fell(o_mem_oe_n) && data_ff) begin
			poll_ff <= 1'b1;
		end
	end
	// An error seen on a ready poll stays owed until a clear goes out
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			err_ff <= 1'b0;
		end else if ($rose(o_mem_we_n) && o_mem_dq == 16'h0050) begin
			err_ff <= 1'b0;
		end else if (data_ff && !o_mem_oe_n && i_mem_dq[7] && |{i_mem_dq[4:3], i_mem_dq[1]}) begin
			err_ff <= 1'b1;
		end
	end
	chk_strobe_excl: assert property (o_mem_we_n || o_mem_oe_n)
		else $error("write and output enable low together");
	chk_we_in_ce: assert property (!o_mem_we_n |-> !o_mem_ce_n && !o_mem_dq_oe_n)
		else $error("write strobe without chip enable or data drive");
	chk_rd_no_drive: assert property (!o_mem_oe_n |-> !o_mem_ce_n && o_mem_dq_oe_n)
		else $error("output enable without chip enable or with data driven");
	chk_we_width: assert property ($fell(o_mem_we_n) |->
		(!$past(o_mem_ce_n)) ##0 (!o_mem_we_n [*3]) ##1 o_mem_we_n)
		else $error("write strobe shape wrong");
	chk_oe_pulse: assert property ($fell(o_mem_oe_n) |-> !o_mem_oe_n [*3] ##1 o_mem_oe_n)
		else $error("output enable pulse shape wrong");
	chk_prot_addr: assert property (!o_mem_we_n && !setup_ff && o_mem_dq == 16'h00C0 |->
		o_mem_addr[21:7] == 15'h0001)
		else $error("protection setup with bad address lines");
	chk_setup_data: assert property ($rose(o_mem_we_n) && !setup_ff && (o_mem_dq == 16'h0040 ||
		o_mem_dq == 16'h00C0) |-> o_mem_oe_n throughout (##[1:20] !o_mem_we_n))
		else $error("setup not followed by data write");
	chk_ff_after_prog: assert property ($fell(o_mem_we_n) && data_ff |-> o_mem_dq == 16'h00FF)
		else $error("program not closed by array read command");
	chk_poll_first: assert property ($fell(o_mem_we_n) && data_ff |-> poll_ff)
		else $error("program closed without status poll");
	chk_clr_first: assert property ($fell(o_mem_we_n) && err_ff && o_mem_dq != 16'h00FF |->
		o_mem_dq == 16'h0050)
		else $error("command after error without clear");
	cover property ($fell(o_mem_we_n) && o_mem_dq == 16'h00C0);
	cover property ($rose(err_ff));
	cover property ($fell(o_mem_oe_n) && poll_ff);
endmodule

// ===== verif/owps_mem_model.sv
// Behavioural memory: command decoder, status word and protection register.
// Assumes the bench resolves the shared data bus; no clock of its own.
`timescale 1ns/1ps
module owps_mem_model #(
	parameter logic [15:0] FACT_WORD = 16'h3C5A // Arbitrary factory content
) (
	input  wire logic        i_rst_n,
	input  wire logic        i_ce_n,
	input  wire logic        i_we_n,
	input  wire logic        i_oe_n,
	input  wire logic [21:0] i_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_vpp_bad,
	input  wire logic        i_stuck,
	output logic      [15:0] o_dq
);
	logic [15:0] arr [logic [21:0]];
	logic [15:0] prot [0:8];
	logic [15:0] last_q;
	logic [7:0]  sr;
	logic [7:0]  perr;
	logic [7:0]  setup;
	logic [1:0]  mode;
	logic        bad;
	int          busy;
	initial begin
		prot[0] = 16'hFFFE;
		for (int i = 1; i < 9; i++)
			prot[i] = (i < 5) ? FACT_WORD : 16'hFFFF;
		last_q = 16'h0000;
	end
	always @(posedge i_we_n or negedge i_rst_n) begin
		bad = i_addr[21:4] != 18'h00008 || i_addr[3:0] > 4'h8 || !prot[0][1] ||
			(i_addr[3:0] inside {[1:4]} && !prot[0][0]);
		if (!i_rst_n) begin
			mode = 2'h0;
			setup = 8'h00;
			sr = 8'h00;
			perr = 8'h00;
			busy = 0;
		end else if (!i_ce_n && setup != 8'h00) begin
			if (setup == 8'hC0 && bad)
				perr[1] = 1'b1;
			else if (setup == 8'hC0)
				prot[i_addr[3:0]] = prot[i_addr[3:0]] & i_dq;
			else if (i_vpp_bad)
				perr[3] = 1'b1;
			else
				arr[i_addr] = (arr.exists(i_addr) ? arr[i_addr] : 16'hFFFF) & i_dq;
			setup = 8'h00;
			busy = i_stuck ? 1000000 : 3;
		end else if (!i_ce_n) begin
			case (i_dq[7:0])
				8'h40, 8'hC0: begin
					setup = i_dq[7:0];
					mode = 2'h1;
				end
				8'h90: mode = 2'h2;
				8'h50: sr = 8'h00;
				8'hFF: mode = 2'h0;
				default: ;
			endcase
		end
	end
	// Status is refreshed only on an output-enable fall, as the bus cycle defines
	always @(negedge i_oe_n) begin
		if (!i_ce_n) begin
			if (busy > 0)
				busy = busy - 1;
			if (busy == 0) begin
				sr = sr | perr;
				perr = 8'h00;
			end
			if (mode == 2'h1)
				last_q = {8'h00, busy == 0, sr[6:0]};
			else if (mode == 2'h2)
				last_q = (i_addr[21:4] == 18'h00008 && i_addr[3:0] < 4'h9) ?
					prot[i_addr[3:0]] : 16'h0000;
			else
				last_q = arr.exists(i_addr) ? arr[i_addr] : 16'hFFFF;
		end
	end
	// Released bus shows the inverse so a stale sample cannot pass
	assign o_dq = (!i_ce_n && !i_oe_n) ? last_q : ~last_q;
endmodule

// ===== verif/tb.sv
// Self-checking bench for owps_ctrl driving the behavioural memory.
// Assumes one 25 MHz clock; expected values follow the memory rules.
`timescale 1ns/1ps
module tb
	import owps_pkg::*;
;
	localparam logic [15:0] FACT = 16'h3C5A;
	logic        i_ref_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        vpp_bad = 1'b0;
	logic        stuck = 1'b0;
	logic [31:0] o_rdata;
	logic [31:0] v;
	logic        o_irq;
	logic        rst_n, ce_n, we_n, oe_n, dq_oe_n;
	logic [21:0] maddr;
	logic [15:0] mdq, mem_out, bus;
	int          num_errors = 0;
	int          checked = 0;
	int          cyc = 0;
	always #20 i_ref_clk = ~i_ref_clk;
	owps_ctrl #(.POLL_LIMIT(20)) u_owps_ctrl (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_irq(o_irq), .o_mem_rst_n(rst_n), .o_mem_ce_n(ce_n), .o_mem_we_n(we_n),
		.o_mem_oe_n(oe_n), .o_mem_addr(maddr), .o_mem_dq(mdq), .o_mem_dq_oe_n(dq_oe_n),
		.i_mem_dq(bus));
	owps_mem_model #(.FACT_WORD(FACT)) u_owps_mem_model (.i_rst_n(rst_n), .i_ce_n(ce_n),
		.i_we_n(we_n), .i_oe_n(oe_n), .i_addr(maddr), .i_dq(bus), .i_vpp_bad(vpp_bad),
		.i_stuck(stuck), .o_dq(mem_out));
	assign bus = dq_oe_n ? mem_out : mdq;
	task automatic test_done();
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		d = o_rdata;
		@(posedge i_ref_clk);
	endtask
	task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [2:0] code);
		wr(OWPS_REG_ADDR, a);
		wr(OWPS_REG_WDATA, d);
		wr(OWPS_REG_CMD, {29'h0, code});
		do rd(OWPS_REG_STATUS, v); while (v[0] !== 1'b0);
	endtask
	task automatic ist(input logic [31:0] e);
		rd(OWPS_REG_IRQ_STAT, v);
		chk(v, e);
		wr(OWPS_REG_IRQ_STAT, 32'h1F);
	endtask
	task automatic s_prog();
		wr(OWPS_REG_IRQ_MASK, 32'h1F);
		op(32'h12345, 32'h5A3C, OWPS_OP_PROG);
		chk({31'h0, o_irq}, 32'h1);
		ist(32'h1);
		@(negedge i_ref_clk);
		chk({31'h0, o_irq}, 32'h0);
		rd(OWPS_REG_STATUS, v);
		chk(v, 32'h8000);
		op(32'h12345, 32'h0, OWPS_OP_READ_ARRAY);
		rd(OWPS_REG_RDATA, v);
		chk(v, 32'h5A3C);
	endtask
	task automatic s_err();
		wr(OWPS_REG_IRQ_MASK, 32'h0);
		vpp_bad <= 1'b1;
		op(32'h200, 32'h1111, OWPS_OP_PROG);
		rd(OWPS_REG_STATUS, v);
		chk(v, 32'h8802);
		chk({31'h0, o_irq}, 32'h0);
		ist(32'h5);
		vpp_bad <= 1'b0;
		op(32'h200, 32'h0, OWPS_OP_READ_ARRAY);
		rd(OWPS_REG_STATUS, v);
		chk({31'h0, v[1]}, 32'h0);
		rd(OWPS_REG_RDATA, v);
		chk(v, 32'hFFFF);
	endtask
	task automatic s_prot();
		op(32'h81, 32'h0, OWPS_OP_READ_ID);
		rd(OWPS_REG_RDATA, v);
		chk(v, {16'h0, FACT});
		op(32'h85, 32'h1234, OWPS_OP_PROT_PROG);
		ist(32'h1);
		op(32'h85, 32'h0, OWPS_OP_READ_ID);
		rd(OWPS_REG_RDATA, v);
		chk(v, 32'h1234);
		op(32'h82, 32'h0, OWPS_OP_PROT_PROG);
		ist(32'h9);
		op(32'h89, 32'h0, OWPS_OP_PROT_PROG);
		ist(32'h9);
		op(32'h80, 32'h0, OWPS_OP_LOCK_USER);
		ist(32'h1);
		op(32'h86, 32'h0, OWPS_OP_PROT_PROG);
		ist(32'h9);
		op(32'h86, 32'h0, OWPS_OP_READ_ID);
		rd(OWPS_REG_RDATA, v);
		chk(v, 32'hFFFF);
		op(32'h80, 32'h0, OWPS_OP_READ_ID);
		rd(OWPS_REG_RDATA, v);
		chk(v, 32'hFFFC);
	endtask
	task automatic s_misc();
		rd(8'h1C, v);
		chk(v, 32'h0);
		// Done bits of the earlier reads are still set; clear them first
		wr(OWPS_REG_IRQ_STAT, 32'h1F);
		wr(OWPS_REG_CMD, 32'h7);
		repeat (10) @(posedge i_ref_clk);
		ist(32'h0);
		stuck <= 1'b1;
		op(32'h300, 32'h2222, OWPS_OP_PROG);
		ist(32'h11);
		// A requested clear with an error pending goes out once and ends it
		op(32'h300, 32'h0, OWPS_OP_CLR_STATUS);
		rd(OWPS_REG_STATUS, v);
		chk({30'h0, v[1:0]}, 32'h0);
		ist(32'h1);
		rd(OWPS_REG_CMD, v);
		chk(v, {29'h0, OWPS_OP_CLR_STATUS});
		rd(OWPS_REG_ADDR, v);
		chk(v, 32'h300);
		rd(OWPS_REG_IRQ_MASK, v);
		chk(v, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk({31'h0, rst_n}, 32'h1);
		@(posedge i_ref_clk);
		s_prog();
		s_err();
		s_prot();
		s_misc();
		test_done();
	end
	// Whole run is about a thousand cycles; the ceiling leaves wide margin
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			test_done();
		end
	end
endmodule
bind owps_ctrl owps_ctrl_sva u_owps_ctrl_sva (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
	.o_mem_ce_n(o_mem_ce_n), .o_mem_we_n(o_mem_we_n), .o_mem_oe_n(o_mem_oe_n),
	.o_mem_addr(o_mem_addr), .o_mem_dq(o_mem_dq), .o_mem_dq_oe_n(o_mem_dq_oe_n),
	.i_mem_dq(i_mem_dq));
